//--- hdl/ppcs_defines.svh
`ifndef PPCS_DEFINES_SVH
`define PPCS_DEFINES_SVH
// ==========================================================================
// Register byte addresses on APB
`define PPCS_ADDR_CS1_BASE 12'h000
`define PPCS_ADDR_CS2_BASE 12'h004
`define PPCS_ADDR_CS_MODE 12'h008
`define PPCS_ADDR_SLV_STAT 12'h00c
`define PPCS_ADDR_PAD_CFG 12'h010
`define PPCS_ADDR_XFER_CTRL 12'h014
`define PPCS_ADDR_XFER_STAT 12'h018
`define PPCS_ADDR_SLV_DATA 12'h01c
// ==========================================================================
// Reset values and base write mask
`define PPCS_CS1_BASE_RST 16'h0080
`define PPCS_CS2_BASE_RST 16'h0880
`define PPCS_BASE_MASK 16'hff80
// ==========================================================================
// Mode register fields
`define PPCS_ACK_MODE_SEL_HI 15
`define PPCS_ACK_MODE_SEL_LO 14
`define PPCS_AMW_HI 13
`define PPCS_AMW_LO 11
`define PPCS_DSU_HI 7
`define PPCS_DSU_LO 6
`define PPCS_DSW_HI 5
`define PPCS_DSW_LO 2
`define PPCS_DHW_HI 1
`define PPCS_DHW_LO 0
`define PPCS_MODE_MASK 16'hf8ff
// ==========================================================================
// Timing counts; phases per cycle, time-out and alt wait base in instruction cycles
`define PPCS_PHASES_PER_TCY 4
`define PPCS_ACK_TIMEOUT_TCY 8'hff
`define PPCS_AMW_BASE 4'h3
`endif

//--- hdl/ppcs_pkg.sv
`default_nettype none
package ppcs_pkg;
  // Acknowledge modes
  typedef enum logic [1:0] {
    PPCS_ACK_NONE = 2'h0,
    PPCS_ACK_TMO = 2'h1,
    PPCS_ACK_WAIT = 2'h2,
    PPCS_ACK_RSVD = 2'h3
  } ppcs_ack_t;
  // Transfer sequencer states, one-hot
  typedef enum logic [4:0] {
    PPCS_IDLE = 5'h01,
    PPCS_SETUP = 5'h02,
    PPCS_STROBE = 5'h04,
    PPCS_HOLD = 5'h08,
    PPCS_ALTM = 5'h10
  } ppcs_state_t;
endpackage
`default_nettype wire

//--- hdl/ppcs_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
// Slave buffer access carrier between top and buffer memory
interface ppcs_buf_if;
  logic wr; // Write strobe
  logic [1:0] waddr; // Write slot
  logic [7:0] wdata; // Write byte
  logic [1:0] raddr; // Read slot
  logic [7:0] rdata; // Registered read byte
  modport ctl (output wr, output waddr, output wdata, output raddr, input rdata);
  modport mem (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- hdl/ppcs_buf_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Four-byte slave buffer store, registered read
module ppcs_buf_mem (
  input wire logic pclk,
  ppcs_buf_if.mem bus
);
  logic [7:0] mem [0:3]; // Byte slots
  // Write and registered read; no reset needed on data
  always_ff @(posedge pclk) begin
    if (bus.wr) begin
      mem[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.raddr];
  end
endmodule // ppcs_buf_mem
`default_nettype wire

//--- hdl/ppcs_phase_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppcs_defines.svh"
// ==========================================================================
// Quarter-cycle phase counter: four phases make one instruction cycle
module ppcs_phase_gen (
  input wire logic pclk,
  input wire logic presetn,
  output logic [1:0] phase,
  output logic tcy_tick
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // Tick on the last phase of each instruction cycle
  assign tcy_tick = (phase == 2'h3);
endmodule // ppcs_phase_gen
`default_nettype wire

//--- hdl/ppcs_top.sv
// Behaviour
// - Base address bits 15:7 writable, low zero
// - Distinct reset values for both bases
// - Whole zero write to second base sets cs2_unused flag
// - Acknowledge mode selects none, wait, timeout
// - Timeout limit 255 or strobe field
// - Alt master wait three plus field
// - Setup wait field plus quarter cycle
// - Write strobe field plus half cycle
// - Read strobe field plus three quarters
// - Write hold field plus quarter cycle
// - Input full when every slot full
// - Sticky overflow on write to full
// - Slot full set, cleared by read
// - Output empty when all slots empty
// - Sticky underflow on empty read
// - Slot empty set, cleared by write
// - Byte access clears both pair flags
// - TTL select bit, Schmitt default
// - Timeout sets sticky status flag
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ppcs_defines.svh"
module ppcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_acknowledge_in,
  input wire logic ext_in_wr,
  input wire logic [1:0] ext_in_slot,
  input wire logic [7:0] ext_in_data,
  input wire logic ext_out_rd,
  input wire logic [1:0] ext_out_slot,
  output logic [7:0] ext_out_data,
  output logic port_strobe,
  output logic port_data_oe,
  output logic port_busy,
  output logic ttl_input_select,
  output logic cs2_unused
);
  // ==========================================================================
  // Registers
  logic [15:0] cs1_base_address; // First chip select base
  logic [15:0] cs2_base_address; // Second chip select base
  logic [15:0] chip_select_mode; // Ack and wait fields
  logic [3:0] in_slot_full; // Per-slot input flags
  logic [3:0] out_slot_empty; // Per-slot output flags
  logic in_overflow; // Sticky overflow
  logic out_underflow; // Sticky underflow
  logic timeout_flag; // Sticky transfer time-out
  logic xfer_dir; // Last started direction, 1 = write
  logic [7:0] out_buf [0:3]; // Output bytes seen by the external master
  ppcs_pkg::ppcs_state_t state; // Sequencer state
  logic [7:0] wait_cnt; // Quarter-cycle phase counter
  logic [1:0] phase; // Quarter-cycle phase
  logic [7:0] tmo_tcy; // Whole instruction cycles spent in strobe
  logic [1:0] strobe_ph; // Phase on the edge that enters strobe
  logic [1:0] rd_slot; // Slot of the last local read
  ppcs_buf_if ibuf (); // Input buffer carrier

  // ==========================================================================
  // Address decode
  // Effects only at the edge where the access is answered
  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite;
  wire hit_cs1 = paddr == `PPCS_ADDR_CS1_BASE;
  wire hit_cs2 = paddr == `PPCS_ADDR_CS2_BASE;
  wire hit_mode = paddr == `PPCS_ADDR_CS_MODE;
  wire hit_stat = paddr == `PPCS_ADDR_SLV_STAT;
  wire hit_pad = paddr == `PPCS_ADDR_PAD_CFG;
  wire hit_ctrl = paddr == `PPCS_ADDR_XFER_CTRL;
  wire hit_xst = paddr == `PPCS_ADDR_XFER_STAT;
  wire hit_data = paddr[11:4] == 8'h01 && paddr[3:0] == 4'hc;
  wire hit_any = hit_cs1 | hit_cs2 | hit_mode | hit_stat | hit_pad | hit_ctrl
    | hit_xst | hit_data;

  // Pair mask: a byte access covers both bytes of its word
  function automatic logic [3:0] pair_mask(input logic [1:0] slot);
    pair_mask = slot[1] ? 4'hc : 4'h3;
  endfunction

  // Software slot for local buffer access comes from pwdata[9:8]
  wire [1:0] sw_slot = pwdata[9:8];
  // Local read of input byte: write to data reg with bit 15 set selects read
  wire sw_in_rd = wr_acc & hit_data & pwdata[15];
  // Local write into output byte
  wire sw_out_wr = wr_acc & hit_data & ~pwdata[15];

  // ==========================================================================
  // Mode fields
  wire [1:0] ack_mode_sel = chip_select_mode[`PPCS_ACK_MODE_SEL_HI:`PPCS_ACK_MODE_SEL_LO];
  wire [2:0] alt_master_wait = chip_select_mode[`PPCS_AMW_HI:`PPCS_AMW_LO];
  wire [1:0] data_setup_wait = chip_select_mode[`PPCS_DSU_HI:`PPCS_DSU_LO];
  wire [3:0] strobe_active_wait = chip_select_mode[`PPCS_DSW_HI:`PPCS_DSW_LO];
  wire [1:0] data_hold_wait = chip_select_mode[`PPCS_DHW_HI:`PPCS_DHW_LO];
  wire ack_used = ack_mode_sel == ppcs_pkg::PPCS_ACK_TMO
    || ack_mode_sel == ppcs_pkg::PPCS_ACK_WAIT;
  wire ack_tmo = ack_mode_sel == ppcs_pkg::PPCS_ACK_TMO;
  wire [7:0] tmo_limit = (strobe_active_wait == 4'h0) ? `PPCS_ACK_TIMEOUT_TCY
    : {4'h0, strobe_active_wait};

  // Phase count of a whole-plus-fraction interval, minus one
  function automatic logic [7:0] ph_len(input logic [3:0] whole, input logic [1:0] q);
    ph_len = {2'h0, whole, 2'h0} + {6'h0, q} - 8'h01;
  endfunction

  wire [7:0] setup_len = ph_len({2'h0, data_setup_wait}, 2'h1);
  // strobe length, write half, read three quarters
  wire [7:0] strobe_len = ph_len(strobe_active_wait, xfer_dir ? 2'h2 : 2'h3);
  // hold length, write quarter, read whole cycles
  wire [7:0] hold_len = xfer_dir ? ph_len({2'h0, data_hold_wait}, 2'h1)
    : ph_len({2'h0, data_hold_wait}, 2'h0);
  // a zero read hold skips the hold state entirely
  wire hold_none = hold_len == 8'hff;
  // alternate master wait three plus field
  wire [7:0] altm_len = ph_len(`PPCS_AMW_BASE + {1'h0, alt_master_wait}, 2'h0);
  wire start_req = wr_acc & hit_ctrl & pwdata[0];
  wire alt_req = wr_acc & hit_ctrl & pwdata[2];
  // Strobe ends on ack, time-out or count, by mode
  wire strobe_done_cnt = wait_cnt >= strobe_len;
  // a whole cycle of strobe ends on its entry phase
  wire tcy_done = phase == strobe_ph;
  // Exact to the phase; an 8-bit phase count could not reach 255 cycles
  wire tmo_hit = ack_tmo && tcy_done && tmo_tcy == tmo_limit - 8'h01;
  wire ack_done = port_acknowledge_in;

  ppcs_phase_gen u_phase (
    .pclk(pclk),
    .presetn(presetn),
    .phase(phase),
    .tcy_tick()
  );

  // ==========================================================================
  // Input buffer memory: external writes, local registered reads
  assign ibuf.wr = ext_in_wr;
  assign ibuf.waddr = ext_in_slot;
  assign ibuf.wdata = ext_in_data;
  // remember the slot so a later APB read returns that byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_slot <= 2'h0;
    end else if (sw_in_rd) begin
      rd_slot <= sw_slot;
    end
  end
  // Bypass on the command edge so a back-to-back read sees the byte
  assign ibuf.raddr = sw_in_rd ? sw_slot : rd_slot;
  ppcs_buf_mem u_ibuf (
    .pclk(pclk),
    .bus(ibuf)
  );

  // ==========================================================================
  // Base and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs1_base_address <= `PPCS_CS1_BASE_RST;
      cs2_base_address <= `PPCS_CS2_BASE_RST;
      chip_select_mode <= 16'h0000;
      ttl_input_select <= 1'b0;
    end else if (wr_acc) begin
      if (hit_cs1) cs1_base_address <= pwdata[15:0] & `PPCS_BASE_MASK;
      if (hit_cs2) cs2_base_address <= pwdata[15:0] & `PPCS_BASE_MASK;
      if (hit_mode) chip_select_mode <= pwdata[15:0] & `PPCS_MODE_MASK;
      if (hit_pad) ttl_input_select <= pwdata[0];
    end
  end

  // whole zero write retires second select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs2_unused <= 1'b0;
    end else if (wr_acc && hit_cs2) begin
      cs2_unused <= pwdata[15:0] == 16'h0000;
    end
  end

  // ==========================================================================
  // Slave buffer flags; hardware set wins over clear
  wire [3:0] in_set = ext_in_wr ? (4'h1 << ext_in_slot) : 4'h0;
  wire [3:0] in_clr = sw_in_rd ? pair_mask(sw_slot) : 4'h0;
  wire [3:0] out_clr = sw_out_wr ? pair_mask(sw_slot) : 4'h0;
  wire [3:0] out_set = ext_out_rd ? (4'h1 << ext_out_slot) : 4'h0;
  wire stat_wr = wr_acc & hit_stat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_slot_full <= 4'h0;
      out_slot_empty <= 4'hf;
      in_overflow <= 1'b0;
      out_underflow <= 1'b0;
    end else begin
      // set by data, pair cleared by read
      in_slot_full <= (in_slot_full & ~in_clr) | in_set;
      // pair cleared by write, set by drain
      out_slot_empty <= (out_slot_empty & ~out_clr) | out_set;
      in_overflow <= (in_overflow & ~(stat_wr & ~pwdata[14]))
        | (ext_in_wr & in_slot_full[ext_in_slot]);
      out_underflow <= (out_underflow & ~(stat_wr & ~pwdata[6]))
        | (ext_out_rd & out_slot_empty[ext_out_slot]);
    end
  end
  wire in_all_full = &in_slot_full;
  wire out_all_empty = &out_slot_empty;

  // Output bytes and external read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_buf[0] <= 8'h00;
      out_buf[1] <= 8'h00;
      out_buf[2] <= 8'h00;
      out_buf[3] <= 8'h00;
      ext_out_data <= 8'h00;
    end else begin
      if (sw_out_wr) out_buf[sw_slot] <= pwdata[7:0];
      if (ext_out_rd) ext_out_data <= out_buf[ext_out_slot];
    end
  end

  // ==========================================================================
  // Transfer sequencer in quarter-cycle phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ppcs_pkg::PPCS_IDLE;
      wait_cnt <= 8'h00;
      xfer_dir <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      // time-out sticky, set wins over clear
      if (wr_acc && hit_xst && !pwdata[12]) timeout_flag <= 1'b0;
      case (state)
        ppcs_pkg::PPCS_IDLE: begin
          wait_cnt <= 8'h00;
          if (start_req) begin
            xfer_dir <= pwdata[1];
            state <= ppcs_pkg::PPCS_SETUP;
          end else if (alt_req) begin
            state <= ppcs_pkg::PPCS_ALTM;
          end
        end
        ppcs_pkg::PPCS_SETUP: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt >= setup_len) begin
            wait_cnt <= 8'h00;
            state <= ppcs_pkg::PPCS_STROBE;
          end
        end
        ppcs_pkg::PPCS_STROBE: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (ack_used && ack_done) begin
            wait_cnt <= 8'h00;
            state <= hold_none ? ppcs_pkg::PPCS_IDLE : ppcs_pkg::PPCS_HOLD;
          end else if (tmo_hit) begin
            timeout_flag <= 1'b1;
            wait_cnt <= 8'h00;
            state <= hold_none ? ppcs_pkg::PPCS_IDLE : ppcs_pkg::PPCS_HOLD;
          end else if (!ack_used && strobe_done_cnt) begin
            wait_cnt <= 8'h00;
            state <= hold_none ? ppcs_pkg::PPCS_IDLE : ppcs_pkg::PPCS_HOLD;
          end
        end
        ppcs_pkg::PPCS_HOLD: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt >= hold_len) begin
            state <= ppcs_pkg::PPCS_IDLE;
          end
        end
        ppcs_pkg::PPCS_ALTM: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt >= altm_len) begin
            state <= ppcs_pkg::PPCS_IDLE;
          end
        end
        default: begin
          state <= ppcs_pkg::PPCS_IDLE;
        end
      endcase
    end
  end

  // count whole instruction cycles of strobe for the time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_tcy <= 8'h00;
      strobe_ph <= 2'h0;
    end else if (state != ppcs_pkg::PPCS_STROBE) begin
      // Tracks the phase until the edge that enters strobe
      tmo_tcy <= 8'h00;
      strobe_ph <= phase;
    end else if (tcy_done) begin
      tmo_tcy <= tmo_tcy + 8'h01;
    end
  end

  // Registered port pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_strobe <= 1'b0;
      port_data_oe <= 1'b0;
      port_busy <= 1'b0;
    end else begin
      port_strobe <= state == ppcs_pkg::PPCS_STROBE;
      port_data_oe <= xfer_dir && (state == ppcs_pkg::PPCS_SETUP
        || state == ppcs_pkg::PPCS_STROBE || state == ppcs_pkg::PPCS_HOLD);
      port_busy <= state != ppcs_pkg::PPCS_IDLE;
    end
  end

  // ==========================================================================
  // APB read mux and answer; zero wait states
  wire [15:0] stat_word = {in_all_full, in_overflow, 2'h0, in_slot_full,
    out_all_empty, out_underflow, 2'h0, out_slot_empty};
  wire [15:0] rd_word = hit_cs1 ? cs1_base_address
    : hit_cs2 ? cs2_base_address
    : hit_mode ? chip_select_mode
    : hit_stat ? stat_word
    : hit_pad ? {15'h0000, ttl_input_select}
    : hit_xst ? {port_busy, 2'h0, timeout_flag, 11'h000, cs2_unused}
    : hit_data ? {8'h00, ibuf.rdata}
    : 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= {16'h0000, rd_word};
    end
  end
endmodule // ppcs_top
`default_nettype wire

//--- dv/ppcs_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checks for the chip-select timing block
module ppcs_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port_strobe,
  input wire logic port_data_oe,
  input wire logic port_busy,
  input wire logic ttl_input_select,
  input wire logic cs2_unused
);
  // Completed writes to the pad and second base registers
  logic wr_pad;
  logic wr_cs2;
  assign wr_pad = psel && penable && pready && pwrite && (paddr == 12'h010);
  assign wr_cs2 = psel && penable && pready && pwrite && (paddr == 12'h004);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h01c |-> pslverr)
    else $error("unmapped access without slave error");
  a_ttl_write: assert property (wr_pad |=> ttl_input_select == $past(pwdata[0]))
    else $error("pad select did not take the written bit");
  a_ttl_hold: assert property (!wr_pad |=> $stable(ttl_input_select))
    else $error("pad select changed without a write");
  a_cs2_zero: assert property (wr_cs2 |=> cs2_unused == ($past(pwdata[15:0]) == 16'h0000))
    else $error("second base zero flag wrong after write");
  a_cs2_hold: assert property (!wr_cs2 |=> $stable(cs2_unused))
    else $error("second base zero flag changed without a write");
  // Strobe only after at least one setup cycle
  a_setup_first: assert property ($rose(port_strobe) |-> port_busy && $past(port_busy))
    else $error("strobe rose without a setup cycle");
  // Data must outlive the strobe by a cycle or more
  a_hold_after: assert property ($fell(port_data_oe) |-> !$past(port_strobe))
    else $error("write data released with the strobe");
endmodule // ppcs_top_properties
bind ppcs_top ppcs_top_properties chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .port_strobe(port_strobe), .port_data_oe(port_data_oe), .port_busy(port_busy),
  .ttl_input_select(ttl_input_select), .cs2_unused(cs2_unused)
);
`default_nettype wire

//--- dv/ppcs_ack_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Far-side device: acknowledges a strobe after a set delay
module ppcs_ack_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic port_strobe,
  input wire logic [10:0] ack_delay,
  output logic port_acknowledge_in
);
  // Strobe age in cycles; zero delay means a silent device
  logic [10:0] strobe_age;
  // Acknowledge falls with the strobe so no stale level remains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_age <= 11'h000;
      port_acknowledge_in <= 1'b0;
    end else if (!port_strobe) begin
      strobe_age <= 11'h000;
      port_acknowledge_in <= 1'b0;
    end else begin
      strobe_age <= strobe_age + 11'h001;
      port_acknowledge_in <= (ack_delay != 11'h000) && (strobe_age + 11'h001 >= ack_delay);
    end
  end
endmodule // ppcs_ack_partner
`default_nettype wire

//--- dv/parallel_port_cs_timing_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_port_cs_timing_status_tb;
  // ==========================================
  // Stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ext_in_wr = 1'b0;
  logic ext_out_rd = 1'b0;
  logic [1:0] ext_in_slot = 2'h0;
  logic [1:0] ext_out_slot = 2'h0;
  logic [7:0] ext_in_data = 8'h00;
  logic [10:0] ack_dly = 11'h000;
  logic [31:0] prdata, rd;
  logic [7:0] ext_out_data;
  logic pready, pslverr, er, port_acknowledge_in;
  logic port_strobe, port_data_oe, port_busy, ttl_input_select, cs2_unused;
  int n_mismatch = 0;
  int n_tests = 0;
  int s, su, ho, bz;
  // Register rows: write flag, address, data or expected read, expected error
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} ppcs_row_t;
  ppcs_row_t rows [18] = '{
    '{1'b0, 12'h000, 32'h0080, 1'b0}, '{1'b0, 12'h004, 32'h0880, 1'b0},
    '{1'b0, 12'h00c, 32'h008f, 1'b0},
    '{1'b0, 12'h008, 32'h0000, 1'b0}, '{1'b0, 12'h010, 32'h0000, 1'b0},
    '{1'b1, 12'h000, 32'hffff, 1'b0}, '{1'b0, 12'h000, 32'hff80, 1'b0},
    '{1'b1, 12'h008, 32'hffff, 1'b0}, '{1'b0, 12'h008, 32'hf8ff, 1'b0},
    '{1'b1, 12'h010, 32'hffff, 1'b0}, '{1'b0, 12'h010, 32'h0001, 1'b0},
    '{1'b1, 12'h020, 32'h0000, 1'b1}, '{1'b0, 12'h020, 32'h0000, 1'b1},
    '{1'b1, 12'h004, 32'h0000, 1'b0}, '{1'b0, 12'h018, 32'h0001, 1'b0},
    '{1'b1, 12'h004, 32'h0100, 1'b0}, '{1'b0, 12'h018, 32'h0000, 1'b0},
    '{1'b0, 12'h004, 32'h0100, 1'b0}
  };
  // Transfer rows: mode, write, ack delay, strobe window, setup, hold
  typedef struct packed {
    logic [15:0] m; logic w; logic [10:0] dly, lo, hi; logic [3:0] su, ho;
  } ppcs_xfer_t;
  ppcs_xfer_t xr [9] = '{
    '{16'h0000, 1'b1, 11'h000, 11'h002, 11'h002, 4'h1, 4'h1},
    '{16'h00ff, 1'b1, 11'h000, 11'h03e, 11'h03e, 4'hd, 4'hd},
    '{16'h00ff, 1'b0, 11'h000, 11'h03f, 11'h03f, 4'h0, 4'h0},
    '{16'h0014, 1'b0, 11'h000, 11'h017, 11'h017, 4'h0, 4'h0},
    '{16'hc000, 1'b1, 11'h000, 11'h002, 11'h002, 4'h1, 4'h1},
    '{16'h8000, 1'b1, 11'h014, 11'h014, 11'h018, 4'h1, 4'h1},
    '{16'h4000, 1'b1, 11'h01e, 11'h01e, 11'h022, 4'h1, 4'h1},
    '{16'h4008, 1'b1, 11'h000, 11'h007, 11'h00a, 4'h1, 4'h1},
    '{16'h4000, 1'b1, 11'h000, 11'h3fb, 11'h400, 4'h1, 4'h1}
  };
  // 10 MHz clock
  always #50 pclk = ~pclk;
  ppcs_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_acknowledge_in, .ext_in_wr, .ext_in_slot, .ext_in_data, .ext_out_rd,
    .ext_out_slot, .ext_out_data, .port_strobe, .port_data_oe, .port_busy, .ttl_input_select,
    .cs2_unused);
  ppcs_ack_partner ack_u (.pclk, .presetn, .port_strobe, .ack_delay(ack_dly),
    .port_acknowledge_in);
  // ==========================================
  // Verdict, the only way out of the run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // APB cycle; waits an edge first so back-to-back calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({16'h0, rd[15:0]}, e);
  endtask
  // External master byte access: write to input or read from output
  task automatic ext(input logic w, input logic [1:0] sl, input logic [7:0] d);
    @(posedge pclk);
    ext_in_wr <= w;
    ext_out_rd <= !w;
    ext_in_slot <= sl;
    ext_out_slot <= sl;
    ext_in_data <= d;
    @(posedge pclk);
    ext_in_wr <= 1'b0;
    ext_out_rd <= 1'b0;
  endtask
  // Write control bits c; count setup, strobe, hold and busy cycles
  task automatic xfer(input logic [2:0] c);
    int k;
    s = 0;
    su = 0;
    ho = 0;
    bz = 0;
    k = 0;
    apb(1'b1, 12'h014, {29'h0, c});
    do begin
      @(negedge pclk);
      k++;
      if (port_busy === 1'b1) bz++;
      if (port_strobe === 1'b1) s++;
      else if (port_data_oe === 1'b1 && s == 0) su++;
      else if (port_data_oe === 1'b1) ho++;
    end while ((port_busy === 1'b1 || k < 3) && k < 1500);
    if (k >= 1500) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) chk({16'h0, rd[15:0]}, rows[i].d);
    end
    $display("Register rows done");
    foreach (xr[i]) begin
      apb(1'b1, 12'h008, {16'h0, xr[i].m});
      ack_dly <= xr[i].dly;
      xfer({1'b0, xr[i].w, 1'b1});
      chk({31'h0, s >= xr[i].lo && s <= xr[i].hi}, 32'h1);
      chk(su, {28'h0, xr[i].su});
      chk(ho, {28'h0, xr[i].ho});
      $display("Transfer %0d strobe %0d setup %0d hold %0d", i, s, su, ho);
    end
    apb(1'b1, 12'h008, 32'h00ff);
    xfer(3'h1);
    chk(bz, 32'h58);
    apb(1'b1, 12'h008, 32'h0014);
    xfer(3'h1);
    chk(bz, 32'h18);
    apb(1'b1, 12'h008, 32'h3800);
    xfer(3'h4);
    chk(bz, 32'h28);
    apb(1'b1, 12'h008, 32'h0000);
    xfer(3'h4);
    chk(bz, 32'h0c);
    $display("Read hold and alternate wait done");
    rchk(12'h018, 32'h1000);
    apb(1'b1, 12'h018, 32'h0);
    rchk(12'h018, 32'h0000);
    for (int i = 0; i < 4; i++) ext(1'b1, i[1:0], 8'h10 + i[7:0]);
    rchk(12'h00c, 32'h8f8f);
    ext(1'b1, 2'h1, 8'hff);
    rchk(12'h00c, 32'hcf8f);
    apb(1'b1, 12'h01c, 32'h8200);
    apb(1'b0, 12'h01c, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h12);
    rchk(12'h00c, 32'h438f);
    apb(1'b1, 12'h00c, 32'h0);
    rchk(12'h00c, 32'h038f);
    ext(1'b0, 2'h0, 8'h00);
    rchk(12'h00c, 32'h03cf);
    apb(1'b1, 12'h01c, 32'h00a5);
    rchk(12'h00c, 32'h034c);
    ext(1'b0, 2'h0, 8'h00);
    @(negedge pclk);
    chk({24'h0, ext_out_data}, 32'ha5);
    $display("Slave buffers done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h004, 32'h0880);
    rchk(12'h00c, 32'h008f);
    rchk(12'h010, 32'h0000);
    $display("Reset recovery done");
    final_report();
  end
endmodule // parallel_port_cs_timing_status_tb
`default_nettype wire
